// *** logic/arc_pkg.sv ***
// Purpose: Constants for the reference and converter control block.
// Assumes: Registers are reached over a plain strobe port with 12-bit addresses.
// Notes: Offsets other than the reference control register are local choices.
package arc_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_REF_CTRL = 12'h090c;
  localparam logic [11:0] OFF_CONV_CTRL = 12'h0100;
  localparam logic [11:0] OFF_CONV_CFG = 12'h0104;
  localparam logic [11:0] OFF_RESULT_HIGH = 12'h0108;
  localparam logic [11:0] OFF_RESULT_LOW = 12'h010c;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h0110;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h0114;
  localparam int BIT_REF_EN = 7;
  localparam int BIT_REF_RDY = 6;
  localparam int BIT_CONV_ON = 0;
  localparam int BIT_CONV_GO = 1;
  localparam int CHS_LSB = 2;
  localparam int CHS_W = 6;
  localparam int POS_REF_SELECT_LSB = 0;
  localparam int CS_LSB = 4;
  localparam int RES_W = 10;
  localparam logic [1:0] GAIN_OFF = 2'h0;
  localparam logic [1:0] POS_REF_SELECT_FIXED = 2'h2;
  localparam logic [5:0] CHS_FIXED_REF = 6'h3e;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] RC_CODE = 2'h3;
  localparam logic [3:0] CONV_BITS = 4'ha;
  localparam logic [5:0] RC_DIV = 6'h32;
  typedef enum logic [1:0] {ARC_IDLE, ARC_SAMPLE, ARC_CONVERT} arc_state_e;
endpackage

// *** logic/arc_top.sv ***
// Purpose: Fixed reference control and converter configuration with SAR sequencing.
// Assumes: Analog comparator result arrives on a pin; one system clock.
// Notes: The RC clock is a divided tick modelled in the system clock domain.
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module arc_top (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic [arc_pkg::ADDR_W-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic trigger_in,
  input wire logic cmp_in,
  input wire logic sleep_in,
  output logic reference_enable_out,
  output logic [1:0] reference_gain_select_out,
  output logic [5:0] channel_select_out,
  output logic [1:0] pos_ref_select_out,
  output logic [9:0] dac_code_out,
  output logic sample_out,
  output logic irq_out,
  output logic wake_out
);
  import arc_pkg::*;

  logic ref_en_r;
  logic [1:0] gain_r;
  logic on_r;
  logic go_r;
  logic [5:0] chs_r;
  logic [1:0] pos_ref_select_r;
  logic [2:0] cs_r;
  logic [9:0] result_r;
  logic [9:0] sar_r;
  logic [3:0] bit_r;
  logic done_r;
  logic mask_r;
  logic [7:0] rdata_r;
  logic [5:0] div_r;
  logic [2:0] trig_sync_r;
  logic [2:0] cmp_sync_r;
  logic trig_prev_r;
  logic tick;
  logic finish;
  logic trig_rise;
  logic [5:0] div_lim;
  arc_state_e state_r;

  // Division limit for the selected clock code, minus one.
  // The codes are not in numeric order of the divide ratio.
  // Bit 2 of the code selects the even powers of two for each pair.
  // Both codes whose low bits are all ones select the dedicated RC clock.
  // The RC clock is stood in for by a long divide of the system clock.
  // A real RC source would be asynchronous and need its own crossing logic.
  // Keeping one clock domain here avoids a second domain in the control path.
  // The divider wraps at once when a code change leaves the count above the limit, through the limit test.
  function automatic logic [5:0] div_limit(input logic [2:0] cs);
    case (cs)
      3'h0: div_limit = 6'h01;
      3'h4: div_limit = 6'h03;
      3'h1: div_limit = 6'h07;
      3'h5: div_limit = 6'h0f;
      3'h2: div_limit = 6'h1f;
      3'h6: div_limit = 6'h3f;
      default: div_limit = RC_DIV;
    endcase
  endfunction

  // Input synchronisers; a trigger change counts once stages two and three agree.
  // The trigger and comparator come from outside the clock domain.
  // Stage one may go metastable, so only later stages feed any decision.
  // The trigger edge is taken from the agreed level of stages two and three.
  // The previous-level register resets low, which is the trigger idle level.
  // This avoids a false rising edge straight after reset.
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      trig_sync_r <= 3'h0;
      cmp_sync_r <= 3'h0;
      trig_prev_r <= 1'b0;
    end
    else
    begin
      trig_sync_r <= {trig_sync_r[1:0], trigger_in};
      cmp_sync_r <= {cmp_sync_r[1:0], cmp_in};
      if (trig_sync_r[1] == trig_sync_r[2])
        trig_prev_r <= trig_sync_r[2];
    end
  end
  assign trig_rise = (trig_sync_r[1] == trig_sync_r[2]) && trig_sync_r[2] && !trig_prev_r;

  // Conversion clock divider; all codes but the RC one derive from the system clock.
  // The tick is one system clock wide and marks one bit conversion period.
  // Any change of system clock frequency scales every divided period alike.
  // Software must pick a code whose period meets the converter timing.
  // The divider free-runs so the first tick after a request may come early.
  assign div_lim = div_limit(cs_r);
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      div_r <= 6'h00;
    else if (div_r >= div_lim)
      div_r <= 6'h00;
    else
      div_r <= div_r + 6'h01;
  end
  assign tick = (div_r >= div_lim);

  // Reference control register; unimplemented bits are never stored.
  // Only the enable bit and the gain field hold state.
  // The ready flag is not stored, as it always reads as one here.
  // Gain code zero turns the converter reference buffer off.
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      ref_en_r <= 1'b0;
      gain_r <= GAIN_OFF;
    end
    else if (wr_in && addr_in == OFF_REF_CTRL)
    begin
      ref_en_r <= wdata_in[BIT_REF_EN];
      gain_r <= wdata_in[1:0];
    end
  end

  // Converter configuration registers.
  // The control register holds the enable bit and the channel field.
  // The request bit lives in its own process as hardware also sets it.
  // The configuration register holds the reference and clock selections.
  // The mask register enables the completion interrupt.
  // Changing the channel mid-conversion takes effect at once on the mux.
  // Software is expected to wait an acquisition time after a channel change.
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      on_r <= 1'b0;
      chs_r <= 6'h00;
      pos_ref_select_r <= 2'h0;
      cs_r <= 3'h0;
      mask_r <= 1'b0;
    end
    else if (wr_in)
    begin
      if (addr_in == OFF_CONV_CTRL)
      begin
        on_r <= wdata_in[BIT_CONV_ON];
        chs_r <= wdata_in[CHS_LSB +: CHS_W];
      end
      if (addr_in == OFF_CONV_CFG)
      begin
        pos_ref_select_r <= wdata_in[POS_REF_SELECT_LSB +: 2];
        cs_r <= wdata_in[CS_LSB +: 3];
      end
      if (addr_in == OFF_IRQ_MASK)
        mask_r <= wdata_in[0];
    end
  end

  // Successive approximation sequencer, stepping only on conversion clock ticks.
  // One tick leaves idle and loads the trial code with its top bit set.
  // One tick is spent sampling, with the sample output high.
  // Ten ticks then resolve the bits from the top down.
  // A low comparator clears the trial bit and the next one is set.
  // The last bit is decided in the same edge that loads the result.
  // Clearing the enable or request bit aborts and returns to idle.
  // Sleep aborts unless the RC clock is selected, as the divided clocks stop.
  // Because the logic steps on ticks, control changes may act late.
  assign finish = (state_r == ARC_CONVERT) && tick && (bit_r == 4'h0);
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state_r <= ARC_IDLE;
      sar_r <= 10'h000;
      bit_r <= 4'h0;
      result_r <= 10'h000;
    end
    else if (!on_r || !go_r || (sleep_in && cs_r[1:0] != RC_CODE))
      state_r <= ARC_IDLE; // Writing the request bit low aborts.
    else if (tick)
    begin
      case (state_r)
        ARC_IDLE:
        begin
          state_r <= ARC_SAMPLE;
          sar_r <= {1'b1, 9'h000};
          bit_r <= CONV_BITS - 4'h1;
        end
        ARC_SAMPLE:
          state_r <= ARC_CONVERT;
        ARC_CONVERT:
        begin
          if (!cmp_sync_r[2])
            sar_r[bit_r] <= 1'b0;
          if (bit_r == 4'h0)
          begin
            state_r <= ARC_IDLE;
            result_r <= cmp_sync_r[2] ? sar_r : {sar_r[9:1], 1'b0};
          end
          else
          begin
            sar_r[bit_r - 4'h1] <= 1'b1;
            bit_r <= bit_r - 4'h1;
          end
        end
        default:
          state_r <= ARC_IDLE;
      endcase
    end
  end

  // Request bit: set by software or trigger, cleared on completion.
  // A trigger edge wins over completion so a new request is not lost.
  // Software writes cannot set the request while the converter is not enabled.
  // Setting the request in the same write that enables is not honoured.
  // A trigger seen during sleep is recorded and acted on once allowed.
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      go_r <= 1'b0;
    else if (trig_rise && on_r)
      go_r <= 1'b1;
    else if (finish)
      go_r <= 1'b0;
    else if (wr_in && addr_in == OFF_CONV_CTRL)
      go_r <= wdata_in[BIT_CONV_GO] && on_r;
  end

  // Sticky done flag; a completion wins over a write-one clear.
  // The flag is set at every completion whatever the mask says.
  // Software clears it by writing a one to bit zero of the status register.
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      done_r <= 1'b0;
    else if (finish)
      done_r <= 1'b1;
    else if (wr_in && addr_in == OFF_IRQ_STATUS && wdata_in[0])
      done_r <= 1'b0;
  end

  // Read data, valid in the cycle after the strobe.
  // The data return to zero in every other cycle.
  // Unmapped addresses read as zero.
  // Unimplemented bits of every register read as zero.
  // Reads have no side effects on any flag.
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rdata_r <= RESET_BYTE;
    else if (rd_in)
    begin
      case (addr_in)
        OFF_REF_CTRL: rdata_r <= {ref_en_r, 1'b1, 4'h0, gain_r};
        OFF_CONV_CTRL: rdata_r <= {chs_r, go_r, on_r};
        OFF_CONV_CFG: rdata_r <= {1'b0, cs_r, 2'h0, pos_ref_select_r};
        OFF_RESULT_HIGH: rdata_r <= {6'h00, result_r[9:8]};
        OFF_RESULT_LOW: rdata_r <= result_r[7:0];
        OFF_IRQ_STATUS: rdata_r <= {7'h00, done_r};
        OFF_IRQ_MASK: rdata_r <= {7'h00, mask_r};
        default: rdata_r <= RESET_BYTE;
      endcase
    end
    else
      rdata_r <= RESET_BYTE;
  end

  // Outputs to the analog side; channel selection ignores pin analog select.
  // The fixed reference reaches the converter as a channel and as a reference.
  // The trial code drives the converter's internal digital to analog stage.
  // The interrupt is a level, high while the flag is set and unmasked.
  // The wake output is the same level, gated by the sleep input.
  assign rdata_out = rdata_r;
  assign reference_enable_out = ref_en_r;
  assign reference_gain_select_out = gain_r;
  assign channel_select_out = chs_r;
  assign pos_ref_select_out = pos_ref_select_r;
  assign dac_code_out = sar_r;
  assign sample_out = (state_r == ARC_SAMPLE);
  assign irq_out = done_r && mask_r;
  assign wake_out = done_r && mask_r && sleep_in;
endmodule
`default_nettype wire

// *** sim/arc_chk_asserts.sv ***
// Purpose: Port checks for arc_top.
// Assumes: One clock, async low reset.
// Notes: Attached by the bind below.
`timescale 1ns/100ps
`default_nettype none
module arc_chk (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic [arc_pkg::ADDR_W-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic sleep_in,
  input wire logic reference_enable_out,
  input wire logic [1:0] reference_gain_select_out,
  input wire logic [5:0] channel_select_out,
  input wire logic [1:0] pos_ref_select_out,
  input wire logic irq_out,
  input wire logic wake_out
);
  import arc_pkg::*;
  // Strobes decoded per register.
  wire w_ref = wr_in && addr_in == OFF_REF_CTRL;
  wire r_ref = rd_in && addr_in == OFF_REF_CTRL;
  wire w_cfg = wr_in && addr_in == OFF_CONV_CFG;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  property p_en; w_ref |=> reference_enable_out == $past(wdata_in[7]); endproperty
  a_en: assert property (p_en) else $error("enable not taken");
  property p_gn; w_ref |=> reference_gain_select_out == $past(wdata_in[1:0]); endproperty
  a_gn: assert property (p_gn) else $error("gain not taken");
  property p_rdy; r_ref |=> rdata_out[6]; endproperty
  a_rdy: assert property (p_rdy) else $error("ready low");
  property p_rsv; r_ref |=> rdata_out[5:2] == 4'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("spare bits set");
  property p_res; rd_in && addr_in == OFF_RESULT_HIGH |=> rdata_out[7:2] == 6'h00; endproperty
  a_res: assert property (p_res) else $error("result too wide");
  property p_ch;
    wr_in && addr_in == OFF_CONV_CTRL |=> channel_select_out == $past(wdata_in[7:2]);
  endproperty
  a_ch: assert property (p_ch) else $error("channel not taken");
  property p_pr; w_cfg |=> pos_ref_select_out == $past(wdata_in[1:0]); endproperty
  a_pr: assert property (p_pr) else $error("pos ref not taken");
  property p_wk; wake_out == (irq_out && sleep_in); endproperty
  a_wk: assert property (p_wk) else $error("wake wrong");
  c_irq: cover property ($rose(irq_out));
  c_wk: cover property (wake_out);
  c_ref: cover property (w_ref ##1 r_ref);
endmodule
bind arc_top arc_chk arc_chk_inst (.core_clk_in, .nrst_in, .addr_in, .wdata_in, .wr_in,
  .rd_in, .rdata_out, .sleep_in, .reference_enable_out, .reference_gain_select_out,
  .channel_select_out, .pos_ref_select_out, .irq_out, .wake_out);
`default_nettype wire

// *** sim/test_adc_ref_clock_config.sv ***
// Purpose: Self-checking bench for arc_top.
// Assumes: Comparator held steady per conversion.
// Notes: Steady comparator gives all ones or all zeros.
`timescale 1ns/100ps
`default_nettype none
module test_adc_ref_clock_config;
  import arc_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
  logic trig = 1'b0, cmp = 1'b0, slp = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [7:0] wdata = 8'h00, rdata;
  logic ren, smp, irq, wake;
  logic [1:0] gain, pos_ref_select;
  logic [5:0] channel_select;
  logic [9:0] dac;
  int n_errors = 0;
  int n_compared = 0;
  // Acquisition wait after a channel change, in system clocks.
  localparam int ACQ_CYCLES = 20;
  // Clock at 100 MHz.
  always #5 clk = ~clk;
  arc_top arc_top_inst (.core_clk_in(clk), .nrst_in(nrst), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .trigger_in(trig), .cmp_in(cmp),
    .sleep_in(slp), .reference_enable_out(ren), .reference_gain_select_out(gain),
    .channel_select_out(channel_select), .pos_ref_select_out(pos_ref_select), .dac_code_out(dac),
    .sample_out(smp), .irq_out(irq), .wake_out(wake));
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic wait_irq();
    int i;
    for (i = 0; i < 2000 && irq !== 1'b1; i++) @(posedge clk);
    #1;
    chk(irq, 1'b1);
  endtask
  // Waits for the sample phase of a started conversion.
  task automatic wait_sample();
    int i;
    for (i = 0; i < 200 && smp !== 1'b1; i++) @(posedge clk);
    #1;
    chk(smp, 1'b1);
  endtask
  task automatic end_of_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Reset value, dropped spare bits, enable and every gain code.
  task automatic t_ref();
    int g;
    rd_reg(OFF_REF_CTRL, 8'h40);
    for (g = 0; g < 4; g++)
    begin
      wr_reg(OFF_REF_CTRL, 8'hbc | g[7:0]);
      chk({ren, gain}, {1'b1, g[1:0]});
      rd_reg(OFF_REF_CTRL, 8'hc0 | g[7:0]);
    end
    wr_reg(OFF_REF_CTRL, 8'h00);
    chk(ren, 1'b0);
    rd_reg(12'h07f0, 8'h00);
    $display("t_ref done");
  endtask
  // One conversion for each clock code from 0 to 6 on the reference channel.
  task automatic t_conv();
    int k;
    wr_reg(OFF_IRQ_MASK, 8'h01);
    for (k = 0; k < 7; k++)
    begin
      @(posedge clk);
      cmp <= k[0];
      wr_reg(OFF_CONV_CFG, {1'b0, k[2:0], 2'b00, POS_REF_SELECT_FIXED});
      chk(pos_ref_select, POS_REF_SELECT_FIXED);
      wr_reg(OFF_CONV_CTRL, {CHS_FIXED_REF, 2'b01});
      chk(channel_select, CHS_FIXED_REF);
      repeat (ACQ_CYCLES) @(posedge clk);
      wr_reg(OFF_CONV_CTRL, {CHS_FIXED_REF, 2'b11});
      wait_sample();
      chk(dac, 10'h200);
      wait_irq();
      chk(dac, {10{k[0]}});
      rd_reg(OFF_RESULT_HIGH, {6'h00, {2{k[0]}}});
      rd_reg(OFF_RESULT_LOW, {8{k[0]}});
      rd_reg(OFF_CONV_CTRL, {CHS_FIXED_REF, 2'b01});
      wr_reg(OFF_IRQ_STATUS, 8'h01);
      chk(irq, 1'b0);
    end
    $display("t_conv done");
  endtask
  // Discharge on channel zero as ground: start, then abort after acquisition.
  task automatic t_abort();
    wr_reg(OFF_CONV_CTRL, 8'h01);
    wr_reg(OFF_CONV_CTRL, 8'h03);
    repeat (ACQ_CYCLES) @(posedge clk);
    wr_reg(OFF_CONV_CTRL, 8'h01);
    rd_reg(OFF_CONV_CTRL, 8'h01);
    repeat (1000) @(posedge clk);
    chk(irq, 1'b0);
    $display("t_abort done");
  endtask
  // Trigger edge starts an RC conversion that finishes asleep.
  task automatic t_trig();
    wr_reg(OFF_CONV_CFG, {1'b0, 3'h3, 2'b00, POS_REF_SELECT_FIXED});
    @(posedge clk);
    slp <= 1'b1;
    trig <= 1'b1;
    wait_irq();
    chk(wake, 1'b1);
    wr_reg(OFF_IRQ_MASK, 8'h00);
    chk(irq, 1'b0);
    wr_reg(OFF_IRQ_MASK, 8'h01);
    chk(irq, 1'b1);
    @(posedge clk);
    slp <= 1'b0;
    trig <= 1'b0;
    wr_reg(OFF_IRQ_STATUS, 8'h01);
    chk(irq, 1'b0);
    $display("t_trig done");
  endtask
  // Reset, tests, verdict.
  initial
  begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_ref();
    t_conv();
    t_abort();
    t_trig();
    end_of_test();
  end
  // Watchdog against a hang.
  initial
  begin
    #400000;
    n_errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
